// File: design/iafe_top.sv
// digital control of an image-sensor front end: serial configuration port,
// sampling control, colour sequencing and output latency line
// assumes the analog sampler, amplifiers, offset DAC and converter sit outside;
// the converter code arrives on adc_code_i in the master-clock domain
// Operation
// - line_start high turns shared pins 2,1,0 into shift clock, strobe, data
// - with strobe low, serial data is shifted in on each shift clock rise
// - strobe rising stores last six data bits at the preceding address
// - mode bit 5 clear selects correlated double sampling
// - double sampling holds reference at clock fall, signal at clock rise
// - bit 5 set: single sampling, polarity picks lower or upper black reference
// - after each conversion offset and gain advance per colour mode
// - pixel sequential mode rotates red, green, blue per conversion
// - mux fixed within a line; line sequential steps it each line fall
// - each line_start fall restarts offset and gain at mode's first colour
// - pixel, mosaic and green column modes keep mux on blue input
// - first line fall after mode write arms first line; later ones advance
// - line sequential uses red on first line after a mode write
// - result appears eight sample periods plus one master clock later
// - six pins carry bits 11..6 or 9..4 depending on variant
// - gain bit 5 of active colour enables boost of three
// - gain bits 4..0 set the fine amplifier gain
// - offset bits 4..0 of active colour drive the offset DAC magnitude
// - offset bit 5 makes the offset negative
// - register 7 bit 0 places the analog sections in standby
`include "iafe_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module iafe_top (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic line_start_i,
    input wire logic pixel_sample_clock_i,
    input wire logic shared_pin_2_i,
    input wire logic shared_pin_1_i,
    input wire logic shared_pin_0_i,
    input wire logic [`IAFE_RESULT_W-1:0] adc_code_i,
    output logic [`IAFE_PIN_W-1:0] result_pin_o,
    output logic [2:0] shared_pin_oe_o,
    output logic [1:0] mux_select_o,
    output logic [`IAFE_CODE_MSB:0] offset_mag_o,
    output logic offset_neg_o,
    output logic [`IAFE_CODE_MSB:0] fine_gain_o,
    output logic boost_en_o,
    output logic cds_mode_o,
    output logic [1:0] black_select_o,
    output logic track_ref_o,
    output logic ref_hold_o,
    output logic sig_hold_o,
    output logic standby_o
);

    iafe_pkg::iafe_link_t lk;
    iafe_pkg::iafe_link_t next_lk;
    iafe_pkg::iafe_core_t st;
    iafe_pkg::iafe_core_t next_st;
    logic line_fall;
    logic smp_rise;
    logic smp_fall;
    logic commit;
    logic [`IAFE_ADDR_W-1:0] wr_addr;
    logic [`IAFE_DATA_W-1:0] wr_data;
    logic [`IAFE_MODE_MSB:0] mode;

    function automatic iafe_pkg::iafe_colour_t first_colour(
        input logic [`IAFE_MODE_MSB:0] m,
        input logic [1:0] phase
    );
        iafe_pkg::iafe_colour_t c;
        c = iafe_pkg::IAFE_RED;
        if (m == `IAFE_MODE_LINE_SEQ) begin
            if (phase == 2'h1) begin
                c = iafe_pkg::IAFE_GREEN;
            end else if (phase == 2'h2) begin
                c = iafe_pkg::IAFE_BLUE;
            end
        end else if (m == `IAFE_MODE_MOSAIC) begin
            c = phase[0] ? iafe_pkg::IAFE_GREEN : iafe_pkg::IAFE_RED;
        end else if (m == `IAFE_MODE_GREEN_COL) begin
            c = iafe_pkg::IAFE_GREEN;
        end
        return c;
    endfunction

    function automatic iafe_pkg::iafe_colour_t next_colour(
        input logic [`IAFE_MODE_MSB:0] m,
        input logic [1:0] phase,
        input iafe_pkg::iafe_colour_t cur
    );
        iafe_pkg::iafe_colour_t c;
        c = cur;
        if (m == `IAFE_MODE_MOSAIC) begin
            if (phase[0]) begin
                c = (cur == iafe_pkg::IAFE_GREEN) ? iafe_pkg::IAFE_BLUE : iafe_pkg::IAFE_GREEN;
            end else begin
                c = (cur == iafe_pkg::IAFE_RED) ? iafe_pkg::IAFE_GREEN : iafe_pkg::IAFE_RED;
            end
        end else if (m == `IAFE_MODE_GREEN_COL) begin
            if (cur != iafe_pkg::IAFE_GREEN) begin
                c = iafe_pkg::IAFE_GREEN;
            end else begin
                c = phase[0] ? iafe_pkg::IAFE_BLUE : iafe_pkg::IAFE_RED;
            end
        end else if (m != `IAFE_MODE_LINE_SEQ) begin
            unique case (cur)
                iafe_pkg::IAFE_RED: c = iafe_pkg::IAFE_GREEN;
                iafe_pkg::IAFE_GREEN: c = iafe_pkg::IAFE_BLUE;
                iafe_pkg::IAFE_BLUE: c = iafe_pkg::IAFE_RED;
                default: c = iafe_pkg::IAFE_RED;
            endcase
        end
        return c;
    endfunction

    function automatic logic [1:0] next_phase(
        input logic [`IAFE_MODE_MSB:0] m,
        input logic [1:0] phase
    );
        logic [1:0] p;
        if (m == `IAFE_MODE_LINE_SEQ) begin
            p = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        end else begin
            p = {1'b0, ~phase[0]};
        end
        return p;
    endfunction

    // register address of the active colour, counted from the red entry
    function automatic logic [`IAFE_ADDR_W-1:0] colour_addr(
        input logic [`IAFE_ADDR_W-1:0] base,
        input iafe_pkg::iafe_colour_t c
    );
        return base + {1'b0, c};
    endfunction

    function automatic logic [`IAFE_PIN_W-1:0] pin_slice(
        input logic [`IAFE_RESULT_W-1:0] code
    );
        return `IAFE_RESULT_12BIT ? code[`IAFE_PIN_MSB_12:`IAFE_PIN_LSB_12]
                                  : code[`IAFE_PIN_MSB_10:`IAFE_PIN_LSB_10];
    endfunction

    // serial port: clocked by shared pin 2 itself, which also carries result data while line_start is low
    always_comb begin
        next_lk = lk;
        if (!shared_pin_1_i) begin
            next_lk.shifter = {lk.shifter[`IAFE_FRAME_W-2:0], shared_pin_0_i};
        end else if (!lk.strobe_prev) begin
            next_lk.word = lk.shifter;
            next_lk.toggle = ~lk.toggle;
        end
        next_lk.strobe_prev = shared_pin_1_i;
        // the controller keeps line_start steady around shift edges
        if (!line_start_i) begin
            next_lk = lk;
        end
    end

    always_ff @(posedge shared_pin_2_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // word is stable from its toggle until the next full frame, so the
    // synchronised toggle makes it safe to read here
    assign wr_addr = lk.word[`IAFE_FRAME_W-1:`IAFE_DATA_W];
    assign wr_data = lk.word[`IAFE_DATA_W-1:0];
    assign line_fall = st.ls_s3 & ~st.ls_s2;
    assign smp_rise = ~st.sc_s3 & st.sc_s2;
    assign smp_fall = st.sc_s3 & ~st.sc_s2;
    assign commit = st.tg_s3 ^ st.tg_s2;
    assign mode = st.cfg[`IAFE_ADDR_MODE][`IAFE_MODE_MSB:0];

    always_comb begin
        logic w0;
        logic [1:0] phase;
        logic [`IAFE_DATA_W-1:0] ofs;
        logic [`IAFE_DATA_W-1:0] gain;
        logic [`IAFE_DATA_W-1:0] m0;
        w0 = 1'b0;
        phase = 2'h0;
        ofs = st.cfg[colour_addr(`IAFE_ADDR_RED_OFS, st.colour)];
        gain = st.cfg[colour_addr(`IAFE_ADDR_RED_GAIN, st.colour)];
        m0 = st.cfg[`IAFE_ADDR_MODE];
        next_st = st;
        next_st.ls_s1 = line_start_i;
        next_st.ls_s2 = st.ls_s1;
        next_st.ls_s3 = st.ls_s2;
        next_st.sc_s1 = pixel_sample_clock_i;
        next_st.sc_s2 = st.sc_s1;
        next_st.sc_s3 = st.sc_s2;
        next_st.tg_s1 = lk.toggle;
        next_st.tg_s2 = st.tg_s1;
        next_st.tg_s3 = st.tg_s2;
        if (commit) begin
            next_st.cfg[wr_addr] = wr_data;
            w0 = (wr_addr == `IAFE_ADDR_MODE);
        end
        // a mode write in the same cycle as a line fall stays armed
        next_st.armed = w0 | (st.armed & ~line_fall);
        if (line_fall) begin
            phase = st.armed ? 2'h0 : next_phase(mode, st.line_phase);
            next_st.line_phase = phase;
            next_st.colour = first_colour(mode, phase);
            if (mode == `IAFE_MODE_LINE_SEQ) begin
                next_st.mux = first_colour(mode, phase);
            end else begin
                next_st.mux = iafe_pkg::IAFE_BLUE;
            end
        end else if (smp_rise && !st.ls_s2) begin
            next_st.colour = next_colour(mode, st.line_phase, st.colour);
        end
        // circular delay line: the slot read is the one written eight falls ago
        if (smp_fall) begin
            next_st.pipe[st.ptr] = adc_code_i;
            next_st.ptr = st.ptr + 1'b1;
            next_st.pins = pin_slice(st.pipe[st.ptr]);
        end
        next_st.offset_mag = ofs[`IAFE_CODE_MSB:0];
        next_st.offset_neg = ofs[`IAFE_BIT_OFS_SIGN];
        next_st.fine_gain = gain[`IAFE_CODE_MSB:0];
        next_st.boost = gain[`IAFE_BIT_BOOST];
        next_st.cds = ~m0[`IAFE_BIT_SINGLE];
        if (!m0[`IAFE_BIT_SINGLE]) begin
            next_st.black = iafe_pkg::IAFE_SENSOR;
        end else begin
            next_st.black = m0[`IAFE_BIT_POL] ? iafe_pkg::IAFE_LOWER_REF
                                              : iafe_pkg::IAFE_UPPER_REF;
        end
        next_st.track = st.sc_s2;
        next_st.ref_hold = smp_fall;
        next_st.sig_hold = smp_rise;
        next_st.standby = st.cfg[`IAFE_ADDR_POWER][`IAFE_BIT_STANDBY];
        next_st.oe = {3{~st.ls_s2}};
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= '0;
            // the sample clock rests high between pixels; a synchroniser reset low
            // would show a false rise, and so a false conversion, right after reset
            st.sc_s1 <= 1'b1;
            st.sc_s2 <= 1'b1;
            st.sc_s3 <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign result_pin_o = st.pins;
    assign shared_pin_oe_o = st.oe;
    assign mux_select_o = st.mux;
    assign offset_mag_o = st.offset_mag;
    assign offset_neg_o = st.offset_neg;
    assign fine_gain_o = st.fine_gain;
    assign boost_en_o = st.boost;
    assign cds_mode_o = st.cds;
    assign black_select_o = st.black;
    assign track_ref_o = st.track;
    assign ref_hold_o = st.ref_hold;
    assign sig_hold_o = st.sig_hold;
    assign standby_o = st.standby;

    shift_ignore_a: assert property (@(posedge shared_pin_2_i) disable iff (!arst_n_i)
        (shared_pin_1_i && lk.strobe_prev) || !line_start_i |=> $stable(lk.shifter))
        else $error("shift register moved while strobe high or line idle");

    commit_word_a: assert property (@(posedge shared_pin_2_i) disable iff (!arst_n_i)
        line_start_i && shared_pin_1_i && !lk.strobe_prev
        |=> lk.word == $past(lk.shifter) && lk.toggle != $past(lk.toggle))
        else $error("strobe rise did not capture the frame");

    store_reg_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        commit |=> st.cfg[$past(wr_addr)] == $past(wr_data) ##1 standby_o ==
            st.cfg[`IAFE_ADDR_POWER][`IAFE_BIT_STANDBY])
        else $error("committed word not stored");

    mux_hold_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        $changed(st.mux) |-> $past(line_fall))
        else $error("multiplexer changed inside a line");

    line_first_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && st.armed && mode == `IAFE_MODE_LINE_SEQ
        |=> st.mux == iafe_pkg::IAFE_RED && st.colour == iafe_pkg::IAFE_RED
            ##1 mux_select_o == iafe_pkg::IAFE_RED)
        else $error("first line after mode write not red");

    blue_mux_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && mode != `IAFE_MODE_LINE_SEQ |=> st.mux == iafe_pkg::IAFE_BLUE)
        else $error("single input mode left blue input");

    pixel_restart_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && mode == `IAFE_MODE_PIXEL_SEQ |=> st.colour == iafe_pkg::IAFE_RED)
        else $error("pixel sequence did not restart on red");

    pixel_rotate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        smp_rise && !line_fall && !st.ls_s2 && mode == `IAFE_MODE_PIXEL_SEQ
        && st.colour == iafe_pkg::IAFE_GREEN |=> st.colour == iafe_pkg::IAFE_BLUE)
        else $error("pixel sequence did not step green to blue");

    boost_sel_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        1'b1 |=> boost_en_o ==
            $past(st.cfg[colour_addr(`IAFE_ADDR_RED_GAIN, st.colour)][`IAFE_BIT_BOOST]))
        else $error("boost does not follow active gain register");

    black_sel_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        st.cfg[`IAFE_ADDR_MODE][`IAFE_BIT_SINGLE] && st.cfg[`IAFE_ADDR_MODE][`IAFE_BIT_POL]
        ##1 $stable(st.cfg[`IAFE_ADDR_MODE]) |=> black_select_o == iafe_pkg::IAFE_LOWER_REF)
        else $error("positive polarity did not pick lower reference");

    hold_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        smp_fall |=> ref_hold_o && !sig_hold_o ##1 !ref_hold_o)
        else $error("reference hold pulse wrong");

    latency_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        smp_fall |=> result_pin_o == pin_slice($past(st.pipe[st.ptr])))
        else $error("result pins not loaded from eight-deep line");

    pin_release_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        st.ls_s2 |=> shared_pin_oe_o == 3'h0)
        else $error("shared pins still driven while line start high");

    pin_drive_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !st.ls_s2 |=> shared_pin_oe_o == 3'h7)
        else $error("shared pins not driven while line start low");

    arm_restart_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && st.armed |=> st.line_phase == 2'h0)
        else $error("armed line fall did not select the first line");

    line_step_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && !st.armed && mode == `IAFE_MODE_LINE_SEQ && st.line_phase == 2'h0
        |=> st.mux == iafe_pkg::IAFE_GREEN && st.colour == iafe_pkg::IAFE_GREEN)
        else $error("line sequence did not step red to green");

    sig_pulse_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        smp_rise |=> sig_hold_o && !ref_hold_o ##1 !sig_hold_o)
        else $error("signal hold pulse wrong");

    mode_sample_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        commit && wr_addr == `IAFE_ADDR_MODE && !wr_data[`IAFE_BIT_SINGLE]
        |-> ##2 cds_mode_o && black_select_o == iafe_pkg::IAFE_SENSOR)
        else $error("double sampling not selected by mode write");

    red_offset_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && mode == `IAFE_MODE_PIXEL_SEQ ##1 !commit
        |=> offset_mag_o == st.cfg[`IAFE_ADDR_RED_OFS][`IAFE_CODE_MSB:0]
            && offset_neg_o == st.cfg[`IAFE_ADDR_RED_OFS][`IAFE_BIT_OFS_SIGN])
        else $error("line did not start on the red offset");

    red_gain_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && mode == `IAFE_MODE_PIXEL_SEQ ##1 !commit
        |=> fine_gain_o == st.cfg[`IAFE_ADDR_RED_GAIN][`IAFE_CODE_MSB:0]
            && boost_en_o == st.cfg[`IAFE_ADDR_RED_GAIN][`IAFE_BIT_BOOST])
        else $error("line did not start on the red gain");

    commit_c: cover property (@(posedge clk_i) disable iff (!arst_n_i) commit);
    line_seq_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        line_fall && mode == `IAFE_MODE_LINE_SEQ && !st.armed);
    mosaic_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        smp_rise && mode == `IAFE_MODE_MOSAIC && st.line_phase[0]);
    pixel_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        smp_rise && mode == `IAFE_MODE_PIXEL_SEQ && st.colour == iafe_pkg::IAFE_BLUE);
    lower_ref_c: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        ref_hold_o && black_select_o == iafe_pkg::IAFE_LOWER_REF);

endmodule

`default_nettype wire

// File: design/iafe_cfg.svh
// constants of the image front-end control block: register map, fields, encodings
// assumes inclusion by the package and the top module only
`ifndef IAFE_CFG_SVH
`define IAFE_CFG_SVH

`define IAFE_ADDR_W 3
`define IAFE_DATA_W 6
`define IAFE_FRAME_W 9
`define IAFE_NUM_REGS 8

`define IAFE_ADDR_MODE 3'h0
`define IAFE_ADDR_RED_OFS 3'h1
`define IAFE_ADDR_RED_GAIN 3'h4
`define IAFE_ADDR_POWER 3'h7
`define IAFE_REG_RESET 6'h00

`define IAFE_BIT_SINGLE 5
`define IAFE_BIT_POL 4
`define IAFE_MODE_MSB 2
`define IAFE_BIT_BOOST 5
`define IAFE_BIT_OFS_SIGN 5
`define IAFE_CODE_MSB 4
`define IAFE_BIT_STANDBY 0

`define IAFE_MODE_LINE_SEQ 3'h0
`define IAFE_MODE_PIXEL_SEQ 3'h1
`define IAFE_MODE_MOSAIC 3'h2
`define IAFE_MODE_GREEN_COL 3'h3

`define IAFE_LATENCY 8
`define IAFE_PTR_W 3
`define IAFE_RESULT_W 12
`define IAFE_PIN_W 6
`define IAFE_RESULT_12BIT 1'b1
`define IAFE_PIN_MSB_12 11
`define IAFE_PIN_LSB_12 6
`define IAFE_PIN_MSB_10 9
`define IAFE_PIN_LSB_10 4

`endif

// File: design/iafe_pkg.sv
// types of the image front-end control block
// assumes iafe_cfg.svh on the include path
`include "iafe_cfg.svh"

package iafe_pkg;

    typedef enum logic [1:0] {IAFE_RED, IAFE_GREEN, IAFE_BLUE} iafe_colour_t;

    typedef enum logic [1:0] {IAFE_SENSOR, IAFE_LOWER_REF, IAFE_UPPER_REF} iafe_black_t;

    // serial port state, clocked by the shift clock pin
    typedef struct packed {
        logic [`IAFE_FRAME_W-1:0] shifter;
        logic [`IAFE_FRAME_W-1:0] word;
        logic strobe_prev;
        logic toggle;
    } iafe_link_t;

    // master-clock state
    typedef struct packed {
        logic ls_s1;
        logic ls_s2;
        logic ls_s3;
        logic sc_s1;
        logic sc_s2;
        logic sc_s3;
        logic tg_s1;
        logic tg_s2;
        logic tg_s3;
        logic [`IAFE_NUM_REGS-1:0][`IAFE_DATA_W-1:0] cfg;
        logic armed;
        logic [1:0] line_phase;
        iafe_colour_t colour;
        iafe_colour_t mux;
        logic [`IAFE_LATENCY-1:0][`IAFE_RESULT_W-1:0] pipe;
        logic [`IAFE_PTR_W-1:0] ptr;
        logic [`IAFE_CODE_MSB:0] offset_mag;
        logic offset_neg;
        logic [`IAFE_CODE_MSB:0] fine_gain;
        logic boost;
        logic cds;
        iafe_black_t black;
        logic track;
        logic ref_hold;
        logic sig_hold;
        logic standby;
        logic [`IAFE_PIN_W-1:0] pins;
        logic [2:0] oe;
    } iafe_core_t;

endpackage

// File: test/iafe_ctrl_model.sv
// scanner controller model: serial configuration writes, line start, sample clock
// assumes the bench calls its tasks and resolves the shared pins against the device enables
`timescale 1ns/100ps
`default_nettype none

module iafe_ctrl_model (
    input wire logic clk_i,
    output logic line_start_o,
    output logic sample_clock_o,
    output logic sclk_o,
    output logic strobe_o,
    output logic sdata_o
);
    initial begin
        line_start_o = 1'b0;
        sample_clock_o = 1'b1;
        sclk_o = 1'b0;
        strobe_o = 1'b1;
        sdata_o = 1'b0;
    end

    // shift clock runs only inside a frame; data and strobe change while it is low
    task automatic shift_bit(input logic s, input logic d);
        strobe_o = s;
        sdata_o = d;
        #24 sclk_o = 1'b1;
        #24 sclk_o = 1'b0;
    endtask

    // extra strobe-high clocks carry random data that must be ignored
    task automatic write_reg(input logic [2:0] a, input logic [5:0] d, input int extra);
        logic [8:0] f;
        f = {a, d};
        #7;
        for (int i = 8; i >= 0; i--) shift_bit(1'b0, f[i]);
        for (int i = 0; i < 3 + extra; i++) shift_bit(1'b1, 1'($urandom));
        sdata_o = ~sdata_o;
    endtask

    task automatic set_sample(input logic v);
        @(negedge clk_i) sample_clock_o = v;
    endtask

    task automatic line_high();
        @(negedge clk_i) line_start_o = 1'b1;
        repeat (6) @(negedge clk_i);
    endtask

    task automatic line_low();
        @(negedge clk_i) line_start_o = 1'b0;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

`default_nettype wire

// File: test/test_image_afe_config_and_channel_sequencer.sv
// self-checking bench of the image front-end control block
// assumes the controller model drives the link; expectations queue per sample fall
`timescale 1ns/100ps
`default_nettype none

module test_image_afe_config_and_channel_sequencer;
    typedef struct packed {
        logic [1:0] mux;
        logic [4:0] ofs;
        logic neg;
        logic [4:0] gain;
        logic boost;
        logic cds;
        logic [1:0] black;
        logic stby;
        logic [5:0] pins;
    } iafe_exp_t;

    logic clk = 1'b0;
    logic arst_n = 1'b1;
    logic [11:0] adc_code = 12'h000;
    logic ls, sc, sclk, strobe, sdata;
    logic [5:0] pins;
    logic [2:0] oe;
    logic [1:0] mux_sel, black;
    logic [4:0] ofs, gain;
    logic neg, boost, cds, track, ref_hold, sig_hold, stby;
    // device enables win the shared pins while the line is low
    wire logic p2 = oe[2] ? pins[2] : sclk;
    wire logic p1 = oe[1] ? pins[1] : strobe;
    wire logic p0 = oe[0] ? pins[0] : sdata;
    logic [5:0] regs [8];
    logic [11:0] hist [$];
    iafe_exp_t expq [$];
    iafe_exp_t e;
    int mismatches = 0;
    int comparisons = 0;
    int rises = 0;
    int sigs = 0;

    always #12.5 clk = ~clk;

    iafe_ctrl_model m (.clk_i(clk), .line_start_o(ls), .sample_clock_o(sc), .sclk_o(sclk),
        .strobe_o(strobe), .sdata_o(sdata));

    iafe_top DUT (.clk_i(clk), .arst_n_i(arst_n), .line_start_i(ls),
        .pixel_sample_clock_i(sc), .shared_pin_2_i(p2), .shared_pin_1_i(p1),
        .shared_pin_0_i(p0), .adc_code_i(adc_code), .result_pin_o(pins),
        .shared_pin_oe_o(oe), .mux_select_o(mux_sel), .offset_mag_o(ofs),
        .offset_neg_o(neg), .fine_gain_o(gain), .boost_en_o(boost), .cds_mode_o(cds),
        .black_select_o(black), .track_ref_o(track), .ref_hold_o(ref_hold),
        .sig_hold_o(sig_hold), .standby_o(stby));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    function automatic logic [1:0] colour(input logic [2:0] md, input int ln, input int k);
        case (md)
            3'h0: return 2'(ln % 3);
            3'h2: return ln % 2 == 0 ? 2'(k % 2) : 2'(1 + k % 2);
            3'h3: return ln % 2 == 0 ? (k % 2 == 0 ? 2'h1 : 2'h0) : 2'(1 + k % 2);
            default: return 2'(k % 3);
        endcase
    endfunction

    task automatic wr(input logic [2:0] a, input logic [5:0] d);
        m.write_reg(a, d, int'($urandom_range(3)));
        regs[a] = d;
    endtask

    // one pixel: note the expectation, then fall and rise of the sample clock
    task automatic pixel(input logic [1:0] c, input logic [1:0] mx);
        iafe_exp_t x;
        logic [11:0] code;
        code = 12'($urandom);
        x.mux = mx;
        x.ofs = regs[1 + c][4:0];
        x.neg = regs[1 + c][5];
        x.gain = regs[4 + c][4:0];
        x.boost = regs[4 + c][5];
        x.cds = ~regs[0][5];
        x.black = regs[0][5] ? (regs[0][4] ? 2'h1 : 2'h2) : 2'h0;
        x.stby = regs[7][0];
        x.pins = hist.size() >= 8 ? hist[hist.size() - 8][11:6] : 6'h00;
        hist.push_back(code);
        expq.push_back(x);
        m.set_sample(1'b0);
        adc_code = code;
        repeat (6) @(negedge clk);
        m.set_sample(1'b1);
        rises++;
        repeat (6) @(negedge clk);
    endtask

    always @(negedge clk) begin
        if (sig_hold === 1'b1) begin
            sigs++;
            check("track_at_sig", 32'(track), 32'h1);
        end
        if (ref_hold === 1'b1) begin
            if (expq.size() == 0) begin
                check("queue_empty", 32'h1, 32'h0);
            end else begin
                e = expq.pop_front();
                check("mux", 32'(mux_sel), 32'(e.mux));
                check("offset", 32'(ofs), 32'(e.ofs));
                check("offset_neg", 32'(neg), 32'(e.neg));
                check("fine_gain", 32'(gain), 32'(e.gain));
                check("boost", 32'(boost), 32'(e.boost));
                check("cds", 32'(cds), 32'(e.cds));
                check("black", 32'(black), 32'(e.black));
                check("standby", 32'(stby), 32'(e.stby));
                check("result", 32'(pins), 32'(e.pins));
                check("track_at_ref", 32'(track), 32'h0);
                check("pin_enable", 32'(oe), 32'h7);
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        $display("[FAIL] watchdog expected done seen hang");
        mismatches++;
        finish_test();
    end

    initial begin
        foreach (regs[i]) regs[i] = 6'h00;
        void'($urandom(32'h4c1d));
        // a real falling edge, so the serial port sees its reset as well
        #1 arst_n = 1'b0;
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        for (int k = 0; k < 4; k++) pixel(2'h0, 2'h0);
        for (int md = 0; md < 5; md++) begin
            m.line_high();
            check("pin_release", 32'(oe), 32'h0);
            for (int a = 1; a < 7; a++) wr(3'(a), 6'($urandom));
            wr(3'h7, {5'h00, 1'($urandom)});
            // sampling bits walk through all four settings
            wr(3'h0, {2'(md + 1), 1'b0, 3'(md)});
            repeat (6) @(negedge clk);
            for (int ln = 0; ln < 3; ln++) begin
                if (ln > 0) m.line_high();
                m.line_low();
                for (int k = 0; k < 4; k++) begin
                    pixel(colour(3'(md), ln, k), md == 0 ? 2'(ln) : 2'h2);
                end
            end
        end
        repeat (10) @(negedge clk);
        check("conversions", 32'(sigs), 32'(rises));
        check("pending", 32'(expq.size()), 32'h0);
        finish_test();
    end
endmodule

`default_nettype wire
